// ==== common/cbt_pkg.sv ====
// package: constants, register map and carrier types of the bit timing / error status block
package cbt_pkg;
   // register byte offsets on the avalon slave
   localparam logic [4:0] OFF_BTC = 5'h00; // bit_timing_config
   localparam logic [4:0] OFF_ESF = 5'h04; // error_status_flags
   localparam logic [4:0] OFF_CTRL = 5'h08; // control: config change, auto recovery, soft reset
   localparam logic [4:0] OFF_IST = 5'h0C; // interrupt status, write one to clear
   localparam logic [4:0] OFF_IMK = 5'h10; // interrupt mask
   // bit_timing_config fields
   localparam int BRP_LSB = 16; // quantum_prescaler 23:16
   localparam int SJW_LSB = 8; // resync_jump_width 9:8
   localparam int TS1_LSB = 3; // first_time_segment 6:3
   localparam int TS2_LSB = 0; // second_time_segment 2:0
   localparam logic [31:0] BTC_WMASK = 32'h00FF_037F; // writable bits
   localparam logic [31:0] BTC_RESET = 32'h0000_0000; // value after reset
   // error_status_flags fields
   localparam int FE_BIT = 24; // form_error_flag
   localparam int BE_BIT = 23; // bit_error_flag
   localparam int SA1_BIT = 22; // stuck_dominant_flag
   localparam int BO_BIT = 18; // bus_off_flag
   // control fields
   localparam int CCR_BIT = 0; // config_change_request
   localparam int ABO_BIT = 1; // automatic_recovery_enable
   localparam int SRST_BIT = 2; // soft reset, self clearing
   // interrupt status / mask fields
   localparam int IRQ_FE = 0; // form error captured
   localparam int IRQ_BE = 1; // bit error captured
   localparam int IRQ_BO = 2; // bus-off entered
   localparam int IRQ_W = 3; // interrupt bits
   // timing constants
   localparam logic [1:0] MCLK_DIV_M1 = 2'h3; // module clock is system clock / 4
   localparam logic [3:0] REC_RUN_M1 = 4'hA; // 11 recessive bits per sequence
   localparam logic [6:0] REC_SEQ_M1 = 7'h7F; // 128 sequences to recover
   localparam int TEC_W = 9; // counter width, bit 8 means 256 reached
   // bit segment state
   typedef enum logic [1:0] {SEG_SYNC, SEG_ONE, SEG_TWO} cbt_seg_t;
   // avalon request from the master
   typedef struct packed {
      logic read;
      logic write;
      logic [4:0] address;
      logic [31:0] writedata;
   } cbt_avs_req_t;
   // per-bit information from the frame engine
   typedef struct packed {
      logic tx_active; // node is transmitting
      logic tx_bit; // bit being sent, 1 recessive
      logic in_arb; // arbitration field in progress
      logic form_err; // fixed-form field had wrong level, pulse
   } cbt_frame_t;
   // whole state of the block
   typedef struct packed {
      logic [1:0] rx_meta; // pin synchroniser
      logic rx_prev; // previous synced level
      logic ack; // bus answer phase
      logic [31:0] rdata; // read data
      logic [31:0] btc; // bit_timing_config
      logic config_change_request; // config_change_request
      logic automatic_recovery_enable; // automatic_recovery_enable
      logic fe; // form_error_flag
      logic be; // bit_error_flag
      logic sa1; // stuck_dominant_flag
      logic bus_off; // bus_off_flag
      logic [IRQ_W-1:0] ist; // interrupt status
      logic [IRQ_W-1:0] imk; // interrupt mask
      logic [1:0] mclk; // module clock divider
      logic [7:0] tq; // prescaler count
      cbt_seg_t seg; // segment of the bit
      logic [4:0] q; // quanta into segment
      logic [4:0] len1; // first segment length incl. resync
      logic rx_bit; // level at last sample point
      logic sample; // sample point pulse
      logic bit_start; // bit start pulse
      logic [3:0] run; // recessive run in bus-off
      logic [6:0] seqs; // finished recessive sequences
      logic clr_cnt; // error counter clear pulse
      logic tx_pin; // registered transmit level
   } cbt_state_t;
endpackage

// ==== hw/cbt_top.sv ====
// bit timing engine with error and status capture and avalon register slave
module cbt_top
   import cbt_pkg::*;
(
   input wire logic CLK_SYS, // 50 MHz system clock
   input wire logic RST_N, // asynchronous reset, active low
   input wire cbt_pkg::cbt_avs_req_t AVS_REQ, // avalon request
   output logic [31:0] AVS_READDATA, // avalon read data
   output logic AVS_WAITREQUEST, // avalon wait request
   input wire logic CAN_RX, // bus receive pin
   output logic CAN_TX, // bus transmit pin, 1 recessive
   input wire cbt_pkg::cbt_frame_t FRAME, // frame engine bit info
   input wire logic [cbt_pkg::TEC_W-1:0] TX_ERR_COUNT, // transmit_error_counter
   output logic RX_BIT, // level at last sample point
   output logic SAMPLE_PULSE, // one cycle at sample point
   output logic BIT_START, // one cycle at bit start
   output logic BUS_OFF, // bus-off state
   output logic CLR_ERR_CNT, // one cycle pulse clearing counters
   output logic IRQ // level interrupt
);
   import cbt_pkg::*;

   // the whole block state lives in one packed struct so that reset,
   // soft reset and the next-state logic all see the same field list
   cbt_state_t s_reg; // registered state
   cbt_state_t s_next; // next state

   logic rx_s; // synced bus level
   logic mtick; // module clock tick
   logic qtick; // time quantum tick
   logic fall; // recessive to dominant edge
   logic [4:0] len1; // effective first segment
   logic [4:0] len2; // effective second segment
   logic [4:0] resync_jump_width; // jump width after cap
   logic [4:0] rem2; // quanta left in segment two
   logic [4:0] ext; // segment one lengthening
   logic hit_btc, hit_esf, hit_ctrl, hit_ist, hit_imk; // address decode
   logic wr; // write takes effect
   logic soft_rst; // soft reset pulse
   logic [31:0] wd; // write data
   logic fe_clr, be_clr; // flag acknowledge
   logic frozen; // a captured flag remains
   logic fe_set, be_set; // new error capture
   logic bit_err; // readback mismatch
   logic bo_enter, bo_leave; // bus-off transitions
   logic [31:0] rd; // read mux

   // synced pin, derived lengths and decode
   // lengths are taken live from the timing register; segment one is
   // latched at the sync quantum so that a write mid-bit cannot cut the
   // bit already in progress short below its sample point unless a resync edge in segment one reloads it from the live field
   always_comb begin
      rx_s = s_reg.rx_meta[1];
      fall = s_reg.rx_prev & ~rx_s;
      len1 = 5'(s_reg.btc[TS1_LSB +: 4]) + 5'd1;
      len2 = 5'(s_reg.btc[TS2_LSB +: 3]) + 5'd1;
      // jump width is capped by segment two and by 4 quanta
      resync_jump_width = 5'(s_reg.btc[SJW_LSB +: 2]) + 5'd1;
      if (resync_jump_width > len2) begin
         resync_jump_width = len2;
      end
      mtick = (s_reg.mclk == MCLK_DIV_M1);
      qtick = mtick & (s_reg.tq == s_reg.btc[BRP_LSB +: 8]);
      rem2 = len2 - s_reg.q;
      ext = (s_reg.q + 5'd1 < resync_jump_width) ? s_reg.q + 5'd1 : resync_jump_width;
      hit_btc = (AVS_REQ.address == OFF_BTC);
      hit_esf = (AVS_REQ.address == OFF_ESF);
      hit_ctrl = (AVS_REQ.address == OFF_CTRL);
      hit_ist = (AVS_REQ.address == OFF_IST);
      hit_imk = (AVS_REQ.address == OFF_IMK);
      wr = AVS_REQ.write & s_reg.ack;
      wd = AVS_REQ.writedata;
      soft_rst = wr & hit_ctrl & wd[SRST_BIT];
      fe_clr = wr & hit_esf & wd[FE_BIT];
      be_clr = wr & hit_esf & wd[BE_BIT];
   end

   // error capture conditions
   // only form and bit errors are captured here; the stuck flag is a level
   // indicator and neither freezes nor is frozen by the other flags
   always_comb begin
      // a flag still standing after this cycle's acknowledge blocks any new capture
      frozen = (s_reg.fe & ~fe_clr) | (s_reg.be & ~be_clr);
      // dominant sent but recessive read in arbitration; any mismatch elsewhere
      bit_err = s_reg.sample & FRAME.tx_active & ~s_reg.bus_off
         & (FRAME.in_arb ? (~FRAME.tx_bit & s_reg.rx_bit)
            : (FRAME.tx_bit != s_reg.rx_bit));
      fe_set = FRAME.form_err & ~frozen;
      be_set = bit_err & ~frozen & ~FRAME.form_err;
      bo_enter = ~s_reg.bus_off & TX_ERR_COUNT[TEC_W-1];
      bo_leave = s_reg.bus_off & ((wr & hit_ctrl & s_reg.config_change_request & ~wd[CCR_BIT])
         | (s_reg.automatic_recovery_enable & s_reg.sample & s_reg.rx_bit
            & (s_reg.run == REC_RUN_M1) & (s_reg.seqs == REC_SEQ_M1)));
   end

   // read data multiplexer, reserved and unmapped bits read zero
   always_comb begin
      rd = 32'h0000_0000;
      if (hit_btc) begin
         rd = s_reg.btc;
      end else if (hit_esf) begin
         rd[FE_BIT] = s_reg.fe;
         rd[BE_BIT] = s_reg.be;
         rd[SA1_BIT] = s_reg.sa1;
         rd[BO_BIT] = s_reg.bus_off;
      end else if (hit_ctrl) begin
         rd[CCR_BIT] = s_reg.config_change_request;
         rd[ABO_BIT] = s_reg.automatic_recovery_enable;
      end else if (hit_ist) begin
         rd[IRQ_W-1:0] = s_reg.ist;
      end else if (hit_imk) begin
         rd[IRQ_W-1:0] = s_reg.imk;
      end
   end

   // next state
   always_comb begin
      s_next = s_reg;
      // two flops before anything reads the pin
      s_next.rx_meta = {s_reg.rx_meta[0], CAN_RX};
      s_next.rx_prev = rx_s;
      s_next.sample = 1'b0;
      s_next.bit_start = 1'b0;
      s_next.clr_cnt = 1'b0;

      // avalon: one wait cycle, read data captured in it
      s_next.ack = (AVS_REQ.read | AVS_REQ.write) & ~s_reg.ack;
      if (AVS_REQ.read & ~s_reg.ack) begin
         s_next.rdata = rd;
      end
      if (wr & hit_btc) begin
         s_next.btc = wd & BTC_WMASK;
      end
      if (wr & hit_ctrl) begin
         s_next.config_change_request = wd[CCR_BIT];
         s_next.automatic_recovery_enable = wd[ABO_BIT];
      end
      if (wr & hit_imk) begin
         s_next.imk = wd[IRQ_W-1:0];
      end

      // module clock divider and quantum prescaler
      // the divider runs free; a quantum always ends on a module clock tick,
      // so a prescaler of zero gives the shortest quantum of four clocks
      s_next.mclk = s_reg.mclk + 2'd1;
      if (mtick) begin
         s_next.tq = qtick ? 8'h00 : s_reg.tq + 8'd1;
      end

      // bit segment sequencing
      if (qtick) begin
         unique case (s_reg.seg)
            SEG_SYNC: begin
               s_next.seg = SEG_ONE;
               s_next.q = 5'd0;
               s_next.len1 = len1;
            end
            SEG_ONE: begin
               s_next.q = s_reg.q + 5'd1;
               if (s_reg.q + 5'd1 >= s_reg.len1) begin
                  s_next.seg = SEG_TWO;
                  s_next.q = 5'd0;
                  s_next.sample = 1'b1;
                  s_next.rx_bit = rx_s;
               end
            end
            SEG_TWO: begin
               s_next.q = s_reg.q + 5'd1;
               if (s_reg.q + 5'd1 >= len2) begin
                  s_next.seg = SEG_SYNC;
                  s_next.q = 5'd0;
                  s_next.bit_start = 1'b1;
               end
            end
            // the fourth code of the segment field is never entered;
            // should it appear, restart the bit at the sync quantum
            default: begin
               s_next.seg = SEG_SYNC;
               s_next.q = 5'd0;
            end
         endcase
      end

      // resync on a falling edge: lengthen segment one or cut segment two short
      if (fall) begin
         if (s_reg.seg == SEG_ONE) begin
            s_next.len1 = len1 + ext;
         end else if (s_reg.seg == SEG_TWO) begin
            if (rem2 <= resync_jump_width) begin
               // edge counts as the sync quantum of the next bit
               s_next.seg = SEG_ONE;
               s_next.q = 5'd0;
               s_next.len1 = len1;
               s_next.tq = 8'h00;
               s_next.bit_start = 1'b1;
            end else begin
               s_next.q = s_reg.q + resync_jump_width;
            end
         end
      end

      // error flags: a set in the clearing cycle wins
      s_next.fe = (s_reg.fe & ~fe_clr) | fe_set;
      s_next.be = (s_reg.be & ~be_clr) | be_set;
      if (s_reg.sample & s_reg.rx_bit) begin
         s_next.sa1 = 1'b0;
      end

      // bus-off: count runs of 11 recessive samples
      // recovery uses the sample points of the local bit timing, so the
      // bus-off time scales with the programmed bit length
      if (s_reg.bus_off & s_reg.sample) begin
         if (!s_reg.rx_bit) begin
            s_next.run = 4'd0;
         end else if (s_reg.run == REC_RUN_M1) begin
            s_next.run = 4'd0;
            s_next.seqs = s_reg.seqs + 7'd1;
         end else begin
            s_next.run = s_reg.run + 4'd1;
         end
      end
      if (bo_enter) begin
         s_next.bus_off = 1'b1;
         s_next.sa1 = 1'b1;
         s_next.run = 4'd0;
         s_next.seqs = 7'd0;
      end else if (bo_leave) begin
         s_next.bus_off = 1'b0;
         s_next.clr_cnt = 1'b1;
      end

      // interrupt status, set wins over write-one clear
      s_next.ist = s_reg.ist & ~((wr & hit_ist) ? wd[IRQ_W-1:0] : {IRQ_W{1'b0}});
      s_next.ist[IRQ_FE] = s_next.ist[IRQ_FE] | fe_set;
      s_next.ist[IRQ_BE] = s_next.ist[IRQ_BE] | be_set;
      s_next.ist[IRQ_BO] = s_next.ist[IRQ_BO] | bo_enter;

      // transmit stays recessive while bus-off; no frame may be sent
      s_next.tx_pin = (FRAME.tx_active & ~s_reg.bus_off) ? FRAME.tx_bit : 1'b1;

      // soft reset returns timing and status to their reset values
      if (soft_rst) begin
         s_next.fe = 1'b0;
         s_next.be = 1'b0;
         s_next.sa1 = 1'b1;
         s_next.bus_off = 1'b0;
         s_next.seg = SEG_SYNC;
         s_next.q = 5'd0;
         s_next.tq = 8'h00;
         s_next.mclk = 2'd0;
         s_next.run = 4'd0;
         s_next.seqs = 7'd0;
         s_next.ist = {IRQ_W{1'b0}};
         s_next.config_change_request = 1'b0;
         s_next.automatic_recovery_enable = 1'b0;
         s_next.btc = BTC_RESET;
      end
   end

   // state register
   // reset values are constants only; the pin synchroniser resets to the
   // recessive level so that no false falling edge follows reset
   always_ff @(posedge CLK_SYS or negedge RST_N) begin
      if (!RST_N) begin
         s_reg <= '0;
         s_reg.rx_meta <= 2'b11;
         s_reg.rx_prev <= 1'b1;
         s_reg.btc <= BTC_RESET;
         s_reg.sa1 <= 1'b1;
         s_reg.seg <= SEG_SYNC;
         s_reg.rx_bit <= 1'b1;
         s_reg.tx_pin <= 1'b1;
      end else begin
         s_reg <= s_next;
      end
   end

   // outputs
   // wait request is combinational on the request so that every access,
   // read or write, sees exactly one wait cycle
   assign AVS_WAITREQUEST = (AVS_REQ.read | AVS_REQ.write) & ~s_reg.ack;
   assign AVS_READDATA = s_reg.rdata;
   assign CAN_TX = s_reg.tx_pin;
   assign RX_BIT = s_reg.rx_bit;
   assign SAMPLE_PULSE = s_reg.sample;
   assign BIT_START = s_reg.bit_start;
   assign BUS_OFF = s_reg.bus_off;
   assign CLR_ERR_CNT = s_reg.clr_cnt;
   assign IRQ = |(s_reg.ist & s_reg.imk);
endmodule // cbt_top

// ==== test/cbt_node_model.sv ====
// far-side bus node: wired-and bus with a pull-up to recessive
module cbt_node_model (
   input wire logic node_tx, // our transmit level
   input wire logic force_dom, // this node sends dominant when high
   output logic bus_level // bus as every node sees it
);
   timeunit 1ns;
   timeprecision 1ns;
   // dominant wins; a released bus returns to recessive through the pull-up
   assign bus_level = node_tx & ~force_dom;
endmodule // cbt_node_model

// ==== test/cbt_top_sva.sv ====
// concurrent checks on the ports of the bit timing and error status block
module cbt_top_sva
   import cbt_pkg::*;
(
   input wire logic CLK_SYS, // system clock
   input wire logic RST_N, // async reset, active low
   input wire cbt_pkg::cbt_avs_req_t AVS_REQ, // avalon request
   input wire logic AVS_WAITREQUEST, // wait request
   input wire logic CAN_TX, // transmit pin
   input wire cbt_pkg::cbt_frame_t FRAME, // frame engine info
   input wire logic [cbt_pkg::TEC_W-1:0] TX_ERR_COUNT, // error count
   input wire logic RX_BIT, // sampled level
   input wire logic SAMPLE_PULSE, // sample point pulse
   input wire logic BIT_START, // bit start pulse
   input wire logic BUS_OFF, // bus-off level
   input wire logic CLR_ERR_CNT, // counter clear pulse
   input wire logic IRQ // level interrupt
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking cb @(posedge CLK_SYS); endclocking
   default disable iff (!RST_N);
   // a fresh request waits exactly one cycle
   sequence s_one_wait; AVS_WAITREQUEST ##1 !AVS_WAITREQUEST; endsequence
   property p_one_wait; $rose(AVS_REQ.read || AVS_REQ.write) |-> s_one_wait; endproperty
   a_one_wait: assert property (p_one_wait) else $error("wait request not one cycle");
   // segments end on quantum ticks or on a resync edge in segment two, four clocks apart at the least
   sequence s_no_start; !BIT_START [*3]; endsequence
   property p_bit_gap; BIT_START |=> s_no_start; endproperty
   a_bit_gap: assert property (p_bit_gap) else $error("bit start too soon");
   property p_sample_gap; SAMPLE_PULSE |-> !BIT_START ##1 !SAMPLE_PULSE [*3]; endproperty
   a_sample_gap: assert property (p_sample_gap) else $error("sample pulse misplaced");
   // the sampled level moves only at a sample point; a move within two cycles of any write is let pass
   property p_rx_hold;
      $changed(RX_BIT) |-> SAMPLE_PULSE || $past(SAMPLE_PULSE) || $past(AVS_REQ.write)
         || $past(AVS_REQ.write, 2);
   endproperty
   a_rx_hold: assert property (p_rx_hold) else $error("sampled level moved");
   property p_busoff_in; TX_ERR_COUNT[8] |=> BUS_OFF; endproperty
   a_busoff_in: assert property (p_busoff_in) else $error("bus-off not entered");
   property p_quiet; BUS_OFF && $past(BUS_OFF) |-> CAN_TX; endproperty
   a_quiet: assert property (p_quiet) else $error("sending in bus-off");
   property p_tx_follow; FRAME.tx_active && !BUS_OFF |=> CAN_TX == $past(FRAME.tx_bit); endproperty
   a_tx_follow: assert property (p_tx_follow) else $error("transmit level wrong");
   // counters are cleared once, when bus-off has been left
   property p_clr; CLR_ERR_CNT |-> !BUS_OFF ##1 !CLR_ERR_CNT; endproperty
   a_clr: assert property (p_clr) else $error("counter clear pulse wrong");
   // an interrupt needs an event or a register write behind it
   property p_irq_cause;
      $rose(IRQ) |-> $past(FRAME.form_err || SAMPLE_PULSE || TX_ERR_COUNT[8] || AVS_REQ.write);
   endproperty
   a_irq_cause: assert property (p_irq_cause) else $error("interrupt without cause");
endmodule // cbt_top_sva

// ==== test/testbench.sv ====
// self-checking bench: registers, bit timing, error capture and bus-off
module testbench;
   timeunit 1ns;
   timeprecision 1ns;
   import cbt_pkg::*;
   logic clk_sys, rst_n, can_rx, can_tx, wreq, irq, rx_bit, smp, bstart, boff, clr, force_dom;
   logic [1:0] mon; // irq and bus-off seen mid-cycle
   logic [31:0] rdata, rd, lfsr; // read data, captured word, random state
   logic [TEC_W-1:0] tec; // transmit error count
   cbt_avs_req_t req; // avalon request
   cbt_frame_t frame; // frame engine stand-in
   int failures, check_count, n, per, clr_cnt, t1, t2, quantum_prescaler, nb;
   int m_fe, m_be, m_sa1, m_bo; // reference flags
   int exp_per[$]; // expected bit lengths in clocks
   cbt_top dut (.CLK_SYS(clk_sys), .RST_N(rst_n), .AVS_REQ(req), .AVS_READDATA(rdata),
      .AVS_WAITREQUEST(wreq), .CAN_RX(can_rx), .CAN_TX(can_tx), .FRAME(frame),
      .TX_ERR_COUNT(tec), .RX_BIT(rx_bit), .SAMPLE_PULSE(smp), .BIT_START(bstart),
      .BUS_OFF(boff), .CLR_ERR_CNT(clr), .IRQ(irq));
   cbt_node_model node (.node_tx(can_tx), .force_dom(force_dom), .bus_level(can_rx));
   initial begin
      clk_sys = 1'b0;
      forever #10 clk_sys = ~clk_sys;
   end
   // levels are read mid-cycle, away from the launching edge
   always @(negedge clk_sys) begin
      mon <= {irq, boff};
      if (clr === 1'b1) clr_cnt++;
   end
   function automatic logic [31:0] lfsr_next(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         failures++;
         $display("unexpected %s: expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic stop_test();
      $display("checks %0d failures %0d", check_count, failures);
      if (failures == 0 && check_count > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   // one avalon access; request held until wait request is seen low
   task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
      logic w;
      req.read <= !wr;
      req.write <= wr;
      req.address <= a;
      req.writedata <= d;
      for (n = 0; n < 20; n++) begin
         @(negedge clk_sys);
         w = wreq;
         rd = rdata;
         @(posedge clk_sys);
         if (w === 1'b0) break;
      end
      if (n == 20) begin failures++; stop_test(); end
      req <= '0;
      @(posedge clk_sys);
   endtask
   // waits for a sample pulse or a bit start, per holds the clocks waited
   task automatic wait_sig(input logic which);
      per = 0;
      do begin
         @(negedge clk_sys);
         per++;
      end while ((which ? smp : bstart) !== 1'b1 && per < 30000);
      if (per >= 30000) begin failures++; stop_test(); end
      @(posedge clk_sys);
   endtask
   task automatic rd_esf();
      bus(1'b0, OFF_ESF, 32'h0);
      chk("flags", rd, (32'(m_fe) << FE_BIT) | (32'(m_be) << BE_BIT)
         | (32'(m_sa1) << SA1_BIT) | (32'(m_bo) << BO_BIT));
   endtask
   task automatic pulse_form();
      frame.form_err <= 1'b1;
      @(posedge clk_sys);
      frame.form_err <= 1'b0;
      repeat (2) @(posedge clk_sys);
      if (m_be == 0) m_fe = 1; // first error only
   endtask
   // we send recessive while the far node drives dominant
   task automatic bit_err(input logic arb);
      frame <= '{1'b1, 1'b1, arb, 1'b0};
      force_dom <= 1'b1;
      repeat (2) wait_sig(1'b1);
      frame <= '0;
      force_dom <= 1'b0;
      @(posedge clk_sys);
      if (!arb && m_fe == 0) m_be = 1; // lost arbitration is no error
   endtask
   initial begin
      rst_n = 1'b0;
      req = '0;
      frame = '0;
      tec = '0;
      force_dom = 1'b1;
      lfsr = 32'h5106_2ec3;
      {failures, check_count, clr_cnt, m_fe, m_be, m_bo} = '0;
      m_sa1 = 1;
      repeat (8) @(posedge clk_sys);
      rst_n <= 1'b1;
      @(posedge clk_sys);
      // bus held dominant so the stuck flag must stay
      bus(1'b0, OFF_BTC, 32'h0);
      chk("timing reset", rd, BTC_RESET);
      rd_esf();
      bus(1'b0, 5'h14, 32'h0);
      chk("unmapped", rd, 32'h0);
      bus(1'b1, OFF_BTC, 32'hFFFF_FFFF);
      bus(1'b0, OFF_BTC, 32'h0);
      chk("timing fields", rd, BTC_WMASK);
      $display("register test done");
      force_dom <= 1'b0;
      // random lengths kept legal by software, last one the longest second segment
      for (int i = 0; i < 5; i++) begin
         lfsr = lfsr_next(lfsr);
         t1 = (i == 4) ? 15 : int'(lfsr[3:0]);
         t2 = (i == 4) ? 7 : int'(lfsr[6:4]);
         quantum_prescaler = (i == 4) ? 1 : 1 + int'(lfsr[9:8]);
         if (t2 < 1) t2 = 1;
         if (t1 < t2) t1 = t2;
         exp_per.push_back(4 * (quantum_prescaler + 1) * (3 + t1 + t2));
         bus(1'b1, OFF_BTC, (32'(quantum_prescaler) << BRP_LSB) | (32'(lfsr[11:10]) << SJW_LSB)
            | (32'(t1) << TS1_LSB) | 32'(t2));
         repeat (3) wait_sig(1'b0);
         chk("bit period", per, exp_per.pop_front());
      end
      m_sa1 = 0;
      rd_esf();
      $display("timing test done");
      bus(1'b1, OFF_BTC, 32'h0001_0011);
      bus(1'b1, OFF_IMK, 32'h0);
      pulse_form();
      chk("irq masked", mon[1], 1'b0);
      bus(1'b1, OFF_IMK, 32'h7);
      chk("irq raised", mon[1], 1'b1);
      bit_err(1'b0);
      rd_esf();
      m_fe = 0;
      bus(1'b1, OFF_ESF, 32'hFE00_0000 | (32'h1 << FE_BIT)); // reserved bits ignored
      bus(1'b1, OFF_IST, 32'h7);
      chk("irq cleared", mon[1], 1'b0);
      rd_esf();
      bit_err(1'b1);
      rd_esf();
      bit_err(1'b0);
      rd_esf();
      chk("irq bit error", mon[1], 1'b1);
      pulse_form();
      rd_esf();
      m_be = 0;
      bus(1'b1, OFF_ESF, 32'h1 << BE_BIT);
      rd_esf();
      $display("error capture test done");
      // bus-off entered with a dominant bus, left by the change request
      force_dom <= 1'b1;
      tec <= 9'h100;
      repeat (3) @(posedge clk_sys);
      m_bo = 1;
      m_sa1 = 1;
      chk("bus-off", mon[0], 1'b1);
      rd_esf();
      tec <= 9'h000;
      nb = clr_cnt;
      bus(1'b1, OFF_CTRL, 32'h1);
      bus(1'b1, OFF_CTRL, 32'h0);
      repeat (2) @(posedge clk_sys);
      m_bo = 0;
      chk("bus-off left", mon[0], 1'b0);
      chk("counter clears", clr_cnt - nb, 1);
      bus(1'b1, OFF_CTRL, 32'h4);
      bus(1'b0, OFF_BTC, 32'h0);
      chk("soft reset timing", rd, BTC_RESET);
      rd_esf();
      // automatic recovery counts recessive bits on an idle bus
      force_dom <= 1'b0;
      bus(1'b1, OFF_BTC, 32'h0001_0009);
      bus(1'b1, OFF_CTRL, 32'h2);
      tec <= 9'h100;
      @(posedge clk_sys);
      tec <= 9'h000;
      repeat (2) @(posedge clk_sys);
      for (nb = 0; nb < 1500 && mon[0] !== 1'b0; nb++) wait_sig(1'b0);
      chk("recovery bits", 32'(nb > 1400 && nb < 1412), 32'h1);
      $display("bus-off test done");
      stop_test();
   end
endmodule // testbench
bind cbt_top cbt_top_sva u_sva (.CLK_SYS(CLK_SYS), .RST_N(RST_N), .AVS_REQ(AVS_REQ),
   .AVS_WAITREQUEST(AVS_WAITREQUEST), .CAN_TX(CAN_TX), .FRAME(FRAME),
   .TX_ERR_COUNT(TX_ERR_COUNT), .RX_BIT(RX_BIT), .SAMPLE_PULSE(SAMPLE_PULSE),
   .BIT_START(BIT_START), .BUS_OFF(BUS_OFF), .CLR_ERR_CNT(CLR_ERR_CNT), .IRQ(IRQ));
